// >>> pbc_pkg.sv
/*
 * Constants for the parallel byte configuration sequencer: pin widths,
 * timing figures and their cycle counts, and the sequencer states.
 * Assumes a 25 MHz system clock.
 */
package pbc_pkg;
	// ----------------------------------------
	// Clock and widths
	// ----------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int DATA_W = 8;
	localparam int TMR_W = 19;
	localparam int UCNT_W = 9;

	// ----------------------------------------
	// Synchroniser bit positions
	// ----------------------------------------
	localparam int SY_REQ = 0;
	localparam int SY_CONFIG_CLOCK = 1;
	localparam int SY_DONE = 2;
	localparam int SY_UCLK = 3;
	localparam int SY_DATA = 4;
	localparam int SY_W = SY_DATA + DATA_W;

	// ----------------------------------------
	// Timing figures and cycle counts
	// ----------------------------------------
	localparam int T_CF2CD_MAX_NS = 800;
	localparam int CF2CD_MAX_CYC = (T_CF2CD_MAX_NS * CLK_MHZ) / 1000;
	localparam int T_POR_MIN_MS = 12;
	localparam int POR_MIN_CYC = T_POR_MIN_MS * CLK_MHZ * 1000;
	localparam int T_STATUS_MIN_US = 10;
	localparam int STATUS_MIN_CYC = T_STATUS_MIN_US * CLK_MHZ;
	localparam int T_STATUS_MAX_US = 100;
	localparam int STATUS_MAX_CYC = T_STATUS_MAX_US * CLK_MHZ;
	localparam int T_CD2UM_MIN_US = 20;
	localparam int CD2UM_MIN_CYC = T_CD2UM_MIN_US * CLK_MHZ;
	localparam int T_CD2UM_MAX_US = 40;
	localparam int CD2UM_MAX_CYC = T_CD2UM_MAX_US * CLK_MHZ;
	localparam int T_CONFIG_CLOCK_PERIOD_NS = 10;
	localparam int CD2CU_PERIODS = 4;
	localparam int CD2CU_CYC_RAW =
		(CD2CU_PERIODS * T_CONFIG_CLOCK_PERIOD_NS * CLK_MHZ + 999) / 1000;
	localparam int CD2CU_CYC = (CD2CU_CYC_RAW < 1) ? 1 : CD2CU_CYC_RAW;
	localparam int USER_CLK_PERIODS = 299;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_POR = 3'h0,
		ST_HOLD = 3'h1,
		ST_CONFIG = 3'h2,
		ST_STARTUP = 3'h3,
		ST_USER = 3'h4
	} pbc_state_t;
endpackage : pbc_pkg

// >>> pbc_edge_if.sv
/*
 * Carries synchronised pin levels and their edges from the synchroniser
 * bank to the sequencer. Assumes both ends share clk_i.
 */
`timescale 1ns/1ps
interface pbc_edge_if #(
	parameter int W = 1
);
	logic [W-1:0] lvl;
	logic [W-1:0] rise;
	logic [W-1:0] fall;

	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface : pbc_edge_if

// >>> pbc_sync_bank.sv
/*
 * Two-flop synchronisers with edge detection, one per input bit.
 * Assumes asynchronous pins; edges are found after the second flop only.
 */
`timescale 1ns/1ps
module pbc_sync_bank #(
	parameter int W = 1
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Raw pins
	input wire logic [W-1:0] pin_i,
	// Synchronised view
	pbc_edge_if.src edge_o
);
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic meta_r;
			logic sync_r;
			logic prev_r;
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
					prev_r <= 1'b0;
				end else if (ce_i) begin
					meta_r <= pin_i[gi];
					sync_r <= meta_r;
					prev_r <= sync_r;
				end
			end
			assign edge_o.lvl[gi] = sync_r;
			assign edge_o.rise[gi] = sync_r & ~prev_r;
			assign edge_o.fall[gi] = ~sync_r & prev_r;
		end
	endgenerate
endmodule : pbc_sync_bank

// >>> pbc_sequencer.sv
/*
 * Device side of the passive parallel byte configuration port: power-up
 * hold-off, reconfiguration on request, byte capture, error reset and
 * startup into user mode. Assumes the open-drain lines are pulled up
 * outside and that the loader core reports completion and errors.
 */
`timescale 1ns/1ps

module pbc_sequencer
	import pbc_pkg::*;
#(
	parameter int POR_CYCLES = POR_MIN_CYC
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Configuration pins
	input wire logic config_request_n_i,
	input wire logic config_clock_i,
	input wire logic [DATA_W-1:0] config_data_i,
	input wire logic config_status_n_i,
	output logic config_status_n_o,
	output logic config_status_n_oe_o,
	input wire logic config_done_i,
	output logic config_done_o,
	output logic config_done_oe_o,
	input wire logic user_startup_clock_i,
	// Options and loader core
	input wire logic use_user_clock_i,
	input wire logic auto_restart_i,
	input wire logic load_complete_i,
	input wire logic load_error_i,
	// Captured bytes and mode
	output logic [DATA_W-1:0] config_byte_o,
	output logic config_byte_valid_o,
	output logic user_clock_en_o,
	output logic user_io_en_o,
	output logic user_mode_o
);
	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	pbc_edge_if #(.W(SY_W)) sy ();

	pbc_sync_bank #(.W(SY_W)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.pin_i({config_data_i, user_startup_clock_i, config_done_i,
			config_clock_i, config_request_n_i}),
		.edge_o(sy)
	);

	logic req_fall;
	logic req_high;
	logic config_clock_rise;
	logic done_high;
	logic uclk_rise;
	assign req_fall = sy.fall[SY_REQ];
	assign req_high = sy.lvl[SY_REQ];
	assign config_clock_rise = sy.rise[SY_CONFIG_CLOCK];
	assign done_high = sy.lvl[SY_DONE];
	assign uclk_rise = sy.rise[SY_UCLK];

	localparam logic [TMR_W-1:0] POR_LAST = TMR_W'(POR_CYCLES - 1);
	localparam logic [TMR_W-1:0] STATUS_LAST = TMR_W'(STATUS_MIN_CYC - 1);
	localparam logic [TMR_W-1:0] CD2UM_LAST = TMR_W'(CD2UM_MIN_CYC - 1);
	localparam logic [TMR_W-1:0] CD2CU_LAST = TMR_W'(CD2CU_CYC - 1);
	localparam logic [UCNT_W-1:0] UCLK_LAST = UCNT_W'(USER_CLK_PERIODS - 1);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	pbc_state_t state_r;
	pbc_state_t state_nxt;
	logic [TMR_W-1:0] timer_r;
	logic [UCNT_W-1:0] ucnt_r;
	logic need_req_r;
	logic opt_user_r;
	logic ucken_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_POR: begin
				if (timer_r == POR_LAST) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// Host stretching request low stretches this too
				if (timer_r >= STATUS_LAST && req_high && !need_req_r) begin
					state_nxt = ST_CONFIG;
				end
			end
			ST_CONFIG: begin
				if (load_error_i) begin
					state_nxt = ST_HOLD;
				end else if (load_complete_i) begin
					state_nxt = ST_STARTUP;
				end
			end
			ST_STARTUP: begin
				if (opt_user_r) begin
					if (ucken_r && uclk_rise && ucnt_r == UCLK_LAST) begin
						state_nxt = ST_USER;
					end
				end else if (done_high && timer_r == CD2UM_LAST) begin
					state_nxt = ST_USER;
				end
			end
			ST_USER: state_nxt = ST_USER;
			default: state_nxt = ST_POR;
		endcase
		// Request fall aborts anything but the power-on hold
		if (req_fall && state_r != ST_POR) begin
			state_nxt = ST_HOLD;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_POR;
		end else if (ce_i) begin
			state_r <= state_nxt;
		end
	end

	// Timer restarts on every state change; in startup it runs once done is high
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			timer_r <= '0;
		end else if (ce_i) begin
			if (state_nxt != state_r) begin
				timer_r <= '0;
			end else if (state_r != ST_STARTUP || done_high) begin
				if (timer_r != '1) begin
					timer_r <= timer_r + 1'b1;
				end
			end
		end
	end

	// Error without auto restart waits for a fresh request pulse
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			need_req_r <= 1'b0;
		end else if (ce_i) begin
			if (req_fall) begin
				need_req_r <= 1'b0;
			end else if (state_r == ST_CONFIG && load_error_i) begin
				need_req_r <= !auto_restart_i;
			end
		end
	end

	// Option is sampled as startup begins so it cannot change mid-way
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			opt_user_r <= 1'b0;
			ucken_r <= 1'b0;
			ucnt_r <= '0;
		end else if (ce_i) begin
			if (state_r != ST_STARTUP) begin
				opt_user_r <= use_user_clock_i;
				ucken_r <= 1'b0;
				if (state_nxt == ST_STARTUP) begin
					ucnt_r <= '0;
				end
			end else if (opt_user_r) begin
				if (done_high && timer_r >= CD2CU_LAST) begin
					ucken_r <= 1'b1;
				end
				if (ucken_r && uclk_rise) begin
					ucnt_r <= ucnt_r + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Pins and outputs
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			config_status_n_o <= 1'b0;
			config_status_n_oe_o <= 1'b1;
			config_done_o <= 1'b0;
			config_done_oe_o <= 1'b1;
			user_clock_en_o <= 1'b0;
			user_io_en_o <= 1'b0;
			user_mode_o <= 1'b0;
		end else if (ce_i) begin
			// Status driven low in power-on and hold, done until startup; released lines float to the pull-up
			config_status_n_oe_o <= (state_nxt == ST_POR || state_nxt == ST_HOLD);
			config_done_oe_o <= (state_nxt != ST_STARTUP && state_nxt != ST_USER);
			user_clock_en_o <= ucken_r && state_nxt == ST_STARTUP;
			user_io_en_o <= (state_nxt == ST_USER);
			user_mode_o <= (state_nxt == ST_USER);
		end
	end

	// No clock timeout: a stopped config clock just waits
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			config_byte_o <= '0;
			config_byte_valid_o <= 1'b0;
		end else if (ce_i) begin
			config_byte_valid_o <= 1'b0;
			if (state_r == ST_CONFIG && config_clock_rise && !req_fall) begin
				config_byte_o <= sy.lvl[SY_DATA +: DATA_W];
				config_byte_valid_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	localparam int STATUS_MIN_I = STATUS_MIN_CYC;
	logic [TMR_W-1:0] low_cnt_r;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_cnt_r <= '0;
		end else if (!config_status_n_oe_o) begin
			low_cnt_r <= '0;
		end else if (low_cnt_r != '1) begin
			low_cnt_r <= low_cnt_r + 1'b1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_done_low_req: assert property (
		ce_i && req_fall && state_r != ST_POR |=> config_done_oe_o)
		else $error("done line not pulled low after request fall");
	a_status_low_req: assert property (
		ce_i && req_fall && state_r != ST_POR |=> config_status_n_oe_o)
		else $error("status line not pulled low after request fall");
	a_status_pulse_min: assert property (
		$fell(config_status_n_oe_o) |-> low_cnt_r >= STATUS_MIN_I)
		else $error("status low pulse too short");
	a_user_lines_high: assert property (
		user_mode_o |-> !config_status_n_oe_o && !config_done_oe_o)
		else $error("open-drain line pulled low in user mode");
	a_done_cfg_low: assert property (
		state_r == ST_CONFIG && $past(state_r) == ST_CONFIG |-> config_done_oe_o)
		else $error("done line released during configuration");
	a_byte_capture: assert property (
		ce_i && state_r == ST_CONFIG && config_clock_rise && !req_fall
		|=> config_byte_valid_o && config_byte_o == $past(sy.lvl[SY_DATA +: DATA_W]))
		else $error("config byte not captured on clock edge");
	a_osc_startup_time: assert property (
		ce_i && state_r == ST_STARTUP && !opt_user_r && done_high
		&& timer_r == CD2UM_LAST && !req_fall |=> state_r == ST_USER)
		else $error("user mode not entered on internal startup count");
	a_uclk_periods: assert property (
		$rose(user_mode_o) && opt_user_r |-> ucnt_r == UCNT_W'(USER_CLK_PERIODS))
		else $error("wrong number of user clock periods at startup");
	a_error_reset: assert property (
		ce_i && state_r == ST_CONFIG && load_error_i |=> config_status_n_oe_o)
		else $error("status line not pulled low on error");

	c_reconfig: cover property (user_mode_o ##1 !user_mode_o);
	c_error: cover property (state_r == ST_CONFIG && load_error_i);
	c_user_clock: cover property ($rose(user_mode_o) && opt_user_r);
	c_osc_startup: cover property ($rose(user_mode_o) && !opt_user_r);
endmodule : pbc_sequencer

// >>> pbc_host_model.sv
/*
 * Host side model of the parallel byte configuration port: request line,
 * configuration clock, byte data and a free running user startup clock.
 * Assumes the bench calls its tasks; task-driven changes land on falling clk_i.
 */
`timescale 1ns/1ps
module pbc_host_model
	import pbc_pkg::*;
(
	// System clock
	input wire logic clk_i,
	// Host driven pins
	output logic config_request_n_o,
	output logic config_clock_o,
	output logic [DATA_W-1:0] config_data_o,
	output logic user_startup_clock_o
);
	// ----------------------------------------
	// Pin state
	// ----------------------------------------
	initial begin
		config_request_n_o = 1'b1;
		config_clock_o = 1'b0;
		config_data_o = 8'h00;
	end

	// Keeps toggling, locked in phase to clk_i, one period per five clk_i periods
	// Offset keeps its edges clear of both clk_i edges, so no sampling race
	initial begin
		user_startup_clock_o = 1'b0;
		#10;
		forever #100 user_startup_clock_o = ~user_startup_clock_o;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task cycles(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cycles

	task set_request(input logic v);
		@(negedge clk_i);
		config_request_n_o = v;
	endtask : set_request

	// Low time fixed, never stretched, so device maxima apply
	task hold_request();
		cycles(60);
	endtask : hold_request

	// Covers both the request-high and status-high waits
	task settle();
		cycles(2600);
	endtask : settle

	// 320 ns link period; clock parked low between bytes
	task send_byte(input logic [DATA_W-1:0] b);
		@(negedge clk_i);
		config_data_o = b;
		cycles(3);
		config_clock_o = 1'b1;
		cycles(4);
		config_clock_o = 1'b0;
		config_data_o = ~b;
	endtask : send_byte
endmodule : pbc_host_model

// >>> pbc_sequencer_tb.sv
/*
 * Self-checking bench for the configuration sequencer with a host model.
 * Assumes open-drain status and done lines with pull-ups, resolved here.
 */
`timescale 1ns/1ps
module pbc_sequencer_tb;
	import pbc_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int POR_C = 50;
	localparam int UCP = 5;
	logic clk_i, rst_i, ce_i, use_user_clock_i, auto_restart_i;
	logic load_complete_i, load_error_i;
	logic req_n, cclk, uclk, st_o, st_oe, dn_o, dn_oe, byte_v, uclk_en, io_en, umode;
	logic [DATA_W-1:0] data, byte_q;
	wire logic status_w = st_oe ? st_o : 1'b1;
	wire logic done_w = dn_oe ? dn_o : 1'b1;
	int seed = 32'hE6352C8D;
	int num_errors = 0;
	int checked = 0;
	int sent = 0;
	int got = 0;
	int n;
	int k;
	int st_low = 0;
	logic [DATA_W-1:0] exp_q[$];

	pbc_host_model host (.clk_i(clk_i), .config_request_n_o(req_n), .config_clock_o(cclk),
		.config_data_o(data), .user_startup_clock_o(uclk));

	pbc_sequencer #(.POR_CYCLES(POR_C)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.config_request_n_i(req_n), .config_clock_i(cclk), .config_data_i(data),
		.config_status_n_i(status_w), .config_status_n_o(st_o), .config_status_n_oe_o(st_oe),
		.config_done_i(done_w), .config_done_o(dn_o), .config_done_oe_o(dn_oe),
		.user_startup_clock_i(uclk), .use_user_clock_i(use_user_clock_i),
		.auto_restart_i(auto_restart_i), .load_complete_i(load_complete_i),
		.load_error_i(load_error_i), .config_byte_o(byte_q), .config_byte_valid_o(byte_v),
		.user_clock_en_o(uclk_en), .user_io_en_o(io_en), .user_mode_o(umode));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task print_verdict();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic pick(input int sel);
		case (sel)
			0: return st_oe;
			1: return dn_oe;
			2: return umode;
			default: return uclk_en;
		endcase
	endfunction : pick

	task wait_lvl(input int sel, input logic v, input int lim, output int cnt);
		cnt = 0;
		while (pick(sel) !== v && cnt < lim) begin
			@(negedge clk_i);
			cnt++;
		end
		if (pick(sel) !== v) begin
			num_errors++;
			$display("[ERR] %0t wait %0d ran out", $time, sel);
			print_verdict();
		end
	endtask : wait_lvl

	// Every capture must match the next byte sent inside a frame
	always @(negedge clk_i) begin
		if (byte_v === 1'b1) begin
			got++;
			if (exp_q.size() == 0) check(32'h1, 32'h0);
			else check({24'h0, byte_q}, {24'h0, exp_q.pop_front()});
		end
	end

	// Length of the current status low pulse, counted from its own start
	always @(posedge clk_i) begin
		st_low <= (st_oe === 1'b1) ? st_low + 1 : 0;
	end

	// ----------------------------------------
	// Scenario tasks
	// ----------------------------------------
	task do_frame(input int nb, input logic fail);
		logic [DATA_W-1:0] b;
		host.settle();
		for (int i = 0; i < nb; i++) begin
			if (i == 2) host.cycles(300);
			b = DATA_W'($random(seed));
			exp_q.push_back(b);
			sent++;
			host.send_byte(b);
		end
		host.cycles(4);
		check({dn_oe, umode}, 2'b10);
		@(negedge clk_i);
		if (fail) load_error_i = 1'b1;
		else load_complete_i = 1'b1;
		@(negedge clk_i);
		load_error_i = 1'b0;
		load_complete_i = 1'b0;
	endtask : do_frame

	task reconfig();
		int n1;
		int n2;
		host.set_request(1'b0);
		wait_lvl(0, 1'b1, CF2CD_MAX_CYC, n1);
		check({dn_oe, umode, io_en}, 3'b100);
		host.hold_request();
		host.set_request(1'b1);
		wait_lvl(0, 1'b0, STATUS_MAX_CYC, n2);
		check(st_low >= STATUS_MIN_CYC, 32'h1);
	endtask : reconfig

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		use_user_clock_i = 1'b0;
		auto_restart_i = 1'b0;
		load_complete_i = 1'b0;
		load_error_i = 1'b0;
		repeat (10) @(negedge clk_i);
		rst_i = 1'b0;
		wait_lvl(0, 1'b0, 5000, n);
		check(n >= POR_C, 32'h1);
		check(dn_oe, 1'b1);
		for (int m = 0; m < 2; m++) begin
			use_user_clock_i = m[0];
			auto_restart_i = 1'($random(seed));
			do_frame(8, 1'b0);
			check(dn_oe, 1'b0);
			if (m == 0) begin
				// Freeze mid-count: the startup timer must lose exactly the frozen cycles
				host.cycles(100);
				ce_i = 1'b0;
				k = 8 + ($random(seed) & 63);
				host.cycles(k);
				check({dn_oe, umode}, 2'b00);
				ce_i = 1'b1;
				wait_lvl(2, 1'b1, CD2UM_MAX_CYC, n);
				check(100 + n >= CD2UM_MIN_CYC, 32'h1);
				check(100 + n <= CD2UM_MIN_CYC + 4, 32'h1);
				check(uclk_en, 1'b0);
			end else begin
				wait_lvl(3, 1'b1, 8, n);
				wait_lvl(2, 1'b1, 1600, n);
				check(n >= (USER_CLK_PERIODS - 1) * UCP, 32'h1);
				check(n <= (USER_CLK_PERIODS + 1) * UCP + 4, 32'h1);
			end
			host.cycles(2);
			check({status_w, done_w, io_en}, 3'b111);
			host.send_byte(DATA_W'($random(seed)));
			host.cycles(4);
			reconfig();
		end
		use_user_clock_i = 1'b0;
		for (int a = 0; a < 2; a++) begin
			auto_restart_i = a[0];
			use_user_clock_i = 1'($random(seed));
			do_frame(3, 1'b1);
			check({st_oe, umode}, 2'b10);
			if (a == 1) begin
				wait_lvl(0, 1'b0, STATUS_MAX_CYC, n);
				check(n >= STATUS_MIN_CYC - 2, 32'h1);
				check(st_low >= STATUS_MIN_CYC, 32'h1);
				do_frame(2, 1'b0);
				check(dn_oe, 1'b0);
			end else begin
				host.cycles(STATUS_MAX_CYC + 100);
				check(st_oe, 1'b1);
				reconfig();
			end
		end
		host.cycles(10);
		check(got, sent);
		// Second reset in mid-startup must restart the power-on hold
		rst_i = 1'b1;
		host.cycles(3);
		check({st_oe, dn_oe, umode, io_en, uclk_en}, 5'b11000);
		rst_i = 1'b0;
		wait_lvl(0, 1'b0, 5000, n);
		check(n >= POR_C, 32'h1);
		check(st_low >= POR_C, 32'h1);
		do_frame(1, 1'b0);
		check(dn_oe, 1'b0);
		host.cycles(10);
		check(got, sent);
		print_verdict();
	end
endmodule : pbc_sequencer_tb
